// ==== src/lmp_sequencer.sv ====
// Purpose: Front-panel indicator drive with three-stage lamp check
// Assumes: Operands and trigger sources are on CLK; faceplate reset is a pin
// Notes: Lamp bit k is scan position k (top-left panel, down each column)
//
// Functional notes
// - Start only when enabled, trigger taken from the selected source.
// - Test covers every lamp, pushbutton lamps included.
// - Stage one lights all 62 while trigger held; ends after one minute.
// - Stage two blanks all, then lights each lamp alone one second.
// - Stage three lights all, then darkens each lamp one second.
// - Stepping starts top-left panel, down each column top to bottom.
// - Later stages abortable anytime; stage one lasts while trigger held.
// - Trigger level holds stage one; rising edges abort later stages.
// - Releasing trigger in stage one moves to stage two.
// - Stage two finishing enters stage three automatically.
// - Fresh trigger activation in stage two or three aborts test.
// - True states keep updating during test and show afterwards.
// - Faceplate reset clears nothing while test runs.
// - Active flag stays high for whole test, drops at end or abort.
// - A start event is logged when a test begins.
// - Trip and alarm lamps follow their selected operands.
// - 48 user lamps, 1-24 on second panel, 25-48 on third.
// - Self-reset lamps follow their operand directly.
// - Latched lamps hold until faceplate, remote or operand reset.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module lmp_sequencer #(
    parameter logic [lmp_pkg::CNT_W-1:0] STEP_CYC = lmp_pkg::STEP_CYC,
    parameter logic [lmp_pkg::CNT_W-1:0] HOLD_LIMIT_CYC =
        lmp_pkg::HOLD_LIMIT_CYC,
    parameter logic [lmp_pkg::CNT_W-1:0] PULSE_MIN_CYC =
        lmp_pkg::PULSE_MIN_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register bus
    input wire lmp_pkg::lmp_apb_req_t APB_REQ,
    output lmp_pkg::lmp_apb_rsp_t APB_RSP,
    // Operands
    input wire logic [lmp_pkg::NUM_TRIG-1:0] TRIG_SRC,
    input wire logic [lmp_pkg::NUM_USER-1:0] USER_OPERAND,
    input wire logic TRIP_OPERAND,
    input wire logic ALARM_OPERAND,
    input wire logic [lmp_pkg::NUM_PB-1:0] PB_LAMP_STATE,
    input wire logic RESET_OPERAND,
    input wire logic FACEPLATE_RESET_PIN,
    // Indicator drive and status
    output logic [lmp_pkg::NUM_LAMPS-1:0] LAMP,
    output logic LAMP_CHECK_ACTIVE_FLAG,
    output logic LAMP_CHECK_STARTED_EVENT
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Step 0 is the blank (or full) lead-in; step k selects lamp k-1
    function automatic logic [lmp_pkg::NUM_LAMPS-1:0] pick_lamp(
        input logic [lmp_pkg::SEL_W-1:0] step
    );
        logic [63:0] one_hot;
        one_hot = 64'h0;
        if (step != 6'h00) begin
            one_hot = 64'h1 << (step - 6'h01);
        end
        return one_hot[lmp_pkg::NUM_LAMPS-1:0];
    endfunction

    lmp_pkg::lmp_regs_t q;
    lmp_pkg::lmp_regs_t d;

    logic trig_raw;
    logic trig_rise;
    logic trig_fall;
    logic step_end;
    logic latch_clr;
    logic [lmp_pkg::NUM_USER-1:0] user_true;
    logic [lmp_pkg::NUM_LAMPS-1:0] true_vec;
    logic apb_access;
    logic apb_commit;
    logic [31:0] rd_word;
    logic rd_err;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.started = 1'b0;
        d.rrst = 1'b0;

        // Faceplate button is asynchronous to CLK
        d.rst_meta = FACEPLATE_RESET_PIN;
        d.rst_sync = q.rst_meta;

        // Qualify the selected trigger: a change must persist for the
        // minimum pulse time before it is believed, in both directions
        trig_raw = TRIG_SRC[q.sel];
        trig_rise = 1'b0;
        trig_fall = 1'b0;
        if (trig_raw != q.flt) begin
            if (q.flt_cnt >= PULSE_MIN_CYC - 36'h1) begin
                d.flt = trig_raw;
                d.flt_cnt = '0;
                trig_rise = trig_raw;
                trig_fall = ~trig_raw;
            end else begin
                d.flt_cnt = q.flt_cnt + 36'h1;
            end
        end else begin
            d.flt_cnt = '0;
        end

        // Latched user lamps; a fresh operand beats a same-cycle clear
        // Only latched-type lamps keep a memory, so switching a lamp to
        // latched never lights it from operand history
        latch_clr = (q.rst_sync & ~q.active) | q.rrst | RESET_OPERAND;
        d.latch = (USER_OPERAND
            | (q.latch & {lmp_pkg::NUM_USER{~latch_clr}}))
            & q.hold_type;
        user_true = (q.hold_type & d.latch)
            | (~q.hold_type & USER_OPERAND);
        // Scan order: trip, alarm, user 1-24, user 25-48, pushbuttons
        true_vec = {PB_LAMP_STATE, user_true, ALARM_OPERAND,
            TRIP_OPERAND};

        // Stage sequencing
        step_end = (q.tmr >= STEP_CYC - 36'h1);
        unique case (q.state)
            lmp_pkg::ST_IDLE: begin
                d.tmr = '0;
                d.step = '0;
                if (q.en && trig_rise) begin
                    d.state = lmp_pkg::ST_ALL_ON;
                    d.started = 1'b1;
                    d.evcnt = q.evcnt + 16'h1;
                end
            end
            lmp_pkg::ST_ALL_ON: begin
                d.tmr = q.tmr + 36'h1;
                if (q.tmr >= HOLD_LIMIT_CYC - 36'h1) begin
                    d.state = lmp_pkg::ST_IDLE;
                end else if (trig_fall) begin
                    d.state = lmp_pkg::ST_WALK_ON;
                    d.tmr = '0;
                    d.step = '0;
                end
            end
            lmp_pkg::ST_WALK_ON, lmp_pkg::ST_WALK_OFF: begin
                d.tmr = q.tmr + 36'h1;
                if (trig_rise) begin
                    d.state = lmp_pkg::ST_IDLE;
                end else if (step_end) begin
                    d.tmr = '0;
                    if (q.step == 6'(lmp_pkg::NUM_LAMPS)) begin
                        d.step = '0;
                        d.state = (q.state == lmp_pkg::ST_WALK_ON)
                            ? lmp_pkg::ST_WALK_OFF
                            : lmp_pkg::ST_IDLE;
                    end else begin
                        d.step = q.step + 6'h1;
                    end
                end
            end
        endcase
        // Disabling the test mid-run drops it cleanly
        if (!q.en) begin
            d.state = lmp_pkg::ST_IDLE;
        end

        d.active = (d.state != lmp_pkg::ST_IDLE);
        // Test owns the lamps; the true vector keeps tracking underneath
        unique case (d.state)
            lmp_pkg::ST_ALL_ON:
                d.lamp = {lmp_pkg::NUM_LAMPS{1'b1}};
            lmp_pkg::ST_WALK_ON:
                d.lamp = pick_lamp(d.step);
            lmp_pkg::ST_WALK_OFF:
                d.lamp = ~pick_lamp(d.step);
            lmp_pkg::ST_IDLE:
                d.lamp = true_vec;
        endcase

        // APB: one wait state, answer and write at the same edge
        apb_access = APB_REQ.psel & APB_REQ.penable;
        apb_commit = apb_access & q.rsp.pready;
        rd_word = 32'h0;
        rd_err = 1'b0;
        unique case (APB_REQ.paddr)
            lmp_pkg::ADDR_CTRL: begin
                rd_word[lmp_pkg::CTRL_EN_BIT] = q.en;
                rd_word[lmp_pkg::CTRL_SEL_LSB +: lmp_pkg::SEL_W] = q.sel;
            end
            lmp_pkg::ADDR_TYPE_LO: rd_word = q.hold_type[31:0];
            lmp_pkg::ADDR_TYPE_HI: rd_word[15:0] = q.hold_type[47:32];
            lmp_pkg::ADDR_CMD: rd_word = 32'h0;
            lmp_pkg::ADDR_STATUS: begin
                rd_word[lmp_pkg::STAT_ACTIVE_BIT] = q.active;
                rd_word[lmp_pkg::STAT_STATE_LSB +: 4] = q.state;
                rd_word[lmp_pkg::STAT_STEP_LSB +: lmp_pkg::SEL_W] = q.step;
                rd_word[lmp_pkg::STAT_TRIG_BIT] = q.flt;
            end
            lmp_pkg::ADDR_EVCNT: rd_word[15:0] = q.evcnt;
            lmp_pkg::ADDR_TRUE_LO: rd_word = true_vec[31:0];
            lmp_pkg::ADDR_TRUE_HI: rd_word[29:0] = true_vec[61:32];
            default: rd_err = 1'b1;
        endcase

        d.rsp.pready = apb_access & ~q.rsp.pready;
        if (apb_access && !q.rsp.pready) begin
            d.rsp.pslverr = rd_err;
            d.rsp.prdata = APB_REQ.pwrite ? 32'h0 : rd_word;
        end else if (apb_commit) begin
            d.rsp.pslverr = 1'b0;
            d.rsp.prdata = 32'h0;
        end

        if (apb_commit && APB_REQ.pwrite && !q.rsp.pslverr) begin
            unique case (APB_REQ.paddr)
                lmp_pkg::ADDR_CTRL: begin
                    d.en = APB_REQ.pwdata[lmp_pkg::CTRL_EN_BIT];
                    d.sel = APB_REQ.pwdata[lmp_pkg::CTRL_SEL_LSB +:
                        lmp_pkg::SEL_W];
                end
                lmp_pkg::ADDR_TYPE_LO:
                    d.hold_type[31:0] = APB_REQ.pwdata;
                lmp_pkg::ADDR_TYPE_HI:
                    d.hold_type[47:32] = APB_REQ.pwdata[15:0];
                lmp_pkg::ADDR_CMD:
                    d.rrst = APB_REQ.pwdata[lmp_pkg::CMD_RRST_BIT];
                default: d.rrst = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            q <= lmp_pkg::REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign APB_RSP = q.rsp;
    assign LAMP = q.lamp;
    assign LAMP_CHECK_ACTIVE_FLAG = q.active;
    assign LAMP_CHECK_STARTED_EVENT = q.started;

endmodule

// ==== src/lmp_pkg.sv ====
// Purpose: Shared constants and types for the indicator lamp sequencer
// Assumes: 250 MHz system clock, APB register access
// Notes: Each time figure is kept in its own unit; cycle counts derive
package lmp_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_LAMPS = 62;
    localparam int NUM_USER = 48;
    localparam int NUM_PB = 12;
    localparam int NUM_TRIG = 64;
    localparam int SEL_W = 6;
    localparam int CNT_W = 36;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 250_000_000;
    localparam longint unsigned STEP_TIME_MS = 1000;
    localparam longint unsigned HOLD_LIMIT_S = 60;
    localparam longint unsigned PULSE_MIN_MS = 250;
    localparam logic [CNT_W-1:0] STEP_CYC =
        CNT_W'(CLK_HZ * STEP_TIME_MS / 1000);
    localparam logic [CNT_W-1:0] HOLD_LIMIT_CYC =
        CNT_W'(CLK_HZ * HOLD_LIMIT_S);
    localparam logic [CNT_W-1:0] PULSE_MIN_CYC =
        CNT_W'((CLK_HZ * PULSE_MIN_MS + 999) / 1000);

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TYPE_LO = 8'h04;
    localparam logic [7:0] ADDR_TYPE_HI = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_EVCNT = 8'h14;
    localparam logic [7:0] ADDR_TRUE_LO = 8'h18;
    localparam logic [7:0] ADDR_TRUE_HI = 8'h1c;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 8;
    localparam int CMD_RRST_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_STEP_LSB = 8;
    localparam int STAT_TRIG_BIT = 16;

    localparam logic RST_EN = 1'b0;
    localparam logic [SEL_W-1:0] RST_SEL = 6'h00;
    localparam logic [NUM_USER-1:0] RST_HOLD_TYPE = 48'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ALL_ON = 4'h2,
        ST_WALK_ON = 4'h4,
        ST_WALK_OFF = 4'h8
    } lmp_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lmp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } lmp_apb_rsp_t;

    typedef struct packed {
        lmp_state_t state;
        logic [SEL_W-1:0] step;
        logic [CNT_W-1:0] tmr;
        logic [CNT_W-1:0] flt_cnt;
        logic flt;
        logic rst_meta;
        logic rst_sync;
        logic [NUM_USER-1:0] latch;
        logic [NUM_LAMPS-1:0] lamp;
        logic active;
        logic started;
        logic en;
        logic [SEL_W-1:0] sel;
        logic [NUM_USER-1:0] hold_type;
        logic rrst;
        logic [15:0] evcnt;
        lmp_apb_rsp_t rsp;
    } lmp_regs_t;

    localparam lmp_regs_t REGS_RST = '{
        state: ST_IDLE,
        en: RST_EN,
        sel: RST_SEL,
        hold_type: RST_HOLD_TYPE,
        default: '0
    };

endpackage

// ==== tb/lmp_seq_checker.sv ====
// Purpose: Port-level checks on the lamp sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Lamp views lag a cycle so abort edges stay out of sight
`timescale 1ns/100ps
module lmp_seq_checker #(
    parameter logic [lmp_pkg::CNT_W-1:0] STEP_CYC = 8,
    parameter logic [lmp_pkg::CNT_W-1:0] HOLD_LIMIT_CYC = 200,
    parameter logic [lmp_pkg::CNT_W-1:0] PULSE_MIN_CYC = 3
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Operands
    input wire logic TRIP_OPERAND,
    input wire logic ALARM_OPERAND,
    input wire logic [lmp_pkg::NUM_PB-1:0] PB_LAMP_STATE,
    // Indicator drive
    input wire logic [lmp_pkg::NUM_LAMPS-1:0] LAMP,
    input wire logic LAMP_CHECK_ACTIVE_FLAG,
    input wire logic LAMP_CHECK_STARTED_EVENT
);
    logic [lmp_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0] hist_q, hist_d;
    logic fl, ev, quiet;
    assign fl = LAMP_CHECK_ACTIVE_FLAG;
    assign ev = LAMP_CHECK_STARTED_EVENT;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Quiet means no test or reset for three cycles, any pipeline fits
    assign quiet = (hist_q == 3'h0) && !fl;
    always_comb begin
        cnt_d = (fl && (&LAMP)) ? cnt_q + 1'b1 : '0;
        hist_d = {hist_q[1:0], RESET || fl};
    end
    always_ff @(posedge CLK) begin
        cnt_q <= RESET ? '0 : cnt_d;
        hist_q <= hist_d;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    evt_pulse_a: assert property (ev |=> !ev)
        else $error("start event longer than one cycle");
    evt_start_a: assert property (ev |-> $rose(fl))
        else $error("start event without flag rise");
    start_evt_a: assert property ($rose(fl) |-> ev)
        else $error("test began without start event");
    start_lit_a: assert property ($rose(fl) |-> &LAMP)
        else $error("first stage not all lamps lit");
    hold_lim_a: assert property (cnt_q <= HOLD_LIMIT_CYC + 2)
        else $error("all-on stage outlived its limit");
    walk_shape_a: assert property ($past(fl) && fl |->
        $countones($past(LAMP)) inside {0, 1, 61, 62})
        else $error("walk shows wrong lamp count");
    walk_order_a: assert property ($past(fl, 2) && $past(fl) && fl &&
        $countones($past(LAMP)) == 1 && $countones($past(LAMP, 2)) == 1
        && $past(LAMP) != $past(LAMP, 2)
        |-> $past(LAMP) == ($past(LAMP, 2) << 1))
        else $error("walk skipped or reversed a lamp");
    trip_alarm_a: assert property (quiet &&
        $past({ALARM_OPERAND, TRIP_OPERAND}) ==
        $past({ALARM_OPERAND, TRIP_OPERAND}, 2)
        |-> LAMP[1:0] == $past({ALARM_OPERAND, TRIP_OPERAND}))
        else $error("trip or alarm lamp not following");
    pb_true_a: assert property (quiet &&
        $past(PB_LAMP_STATE) == $past(PB_LAMP_STATE, 2)
        |-> LAMP[61:50] == $past(PB_LAMP_STATE))
        else $error("pushbutton lamps not showing true state");
    cov_start_c: cover property ($rose(fl));
    cov_end_c: cover property ($fell(fl));
    cov_dark_c: cover property (fl && $countones(LAMP) == 61);
endmodule
bind lmp_sequencer lmp_seq_checker #(
    .STEP_CYC(STEP_CYC),
    .HOLD_LIMIT_CYC(HOLD_LIMIT_CYC),
    .PULSE_MIN_CYC(PULSE_MIN_CYC)
) u_chk (.CLK(CLK), .RESET(RESET), .TRIP_OPERAND(TRIP_OPERAND),
    .ALARM_OPERAND(ALARM_OPERAND), .PB_LAMP_STATE(PB_LAMP_STATE),
    .LAMP(LAMP), .LAMP_CHECK_ACTIVE_FLAG(LAMP_CHECK_ACTIVE_FLAG),
    .LAMP_CHECK_STARTED_EVENT(LAMP_CHECK_STARTED_EVENT));

// ==== tb/lmp_trig_model.sv ====
// Purpose: Operand side that drives the candidate trigger sources
// Assumes: Same clock as the sequencer
// Notes: Unselected sources toggle so a wrong select never fires
`timescale 1ns/100ps
module lmp_trig_model #(
    parameter int MIN_CYC = 3
) (
    // Control
    input wire logic clk,
    input wire logic press,
    input wire logic glitch,
    input wire logic [5:0] sel,
    // Sources
    output logic [63:0] trig_src
);
    int hold = 0;
    logic tog = 1'b0;
    always @(posedge clk) begin
        tog <= ~tog;
        // Release stretched so every press lasts the minimum
        hold <= press ? MIN_CYC : (hold > 0 ? hold - 1 : 0);
    end
    always_comb begin
        trig_src = {32{tog, ~tog}};
        trig_src[sel] = press || (hold > 0) || glitch;
    end
endmodule

// ==== tb/indicator_lamp_test_sequencer_tb.sv ====
// Purpose: Self-checking bench for the lamp sequencer
// Assumes: Short counts: step 8, limit 200, pulse 3
// Notes: Values are read right after an edge, before its updates
`timescale 1ns/100ps
module indicator_lamp_test_sequencer_tb;
    typedef struct packed {logic [61:0] in; logic [61:0] out;} lmp_row_t;
    lmp_row_t rows[5] = '{'{62'h1, 62'h1}, '{62'h2, 62'h2},
        '{62'h3_ffff_ffff_fffc, 62'h3_ffff_ffff_fffc},
        '{62'h3ffc_0000_0000_0000, 62'h3ffc_0000_0000_0000}, '{0, 0}};
    logic clk = 0, rst = 1, press = 0, glitch = 0, ro = 0, fp = 0;
    logic [61:0] tv = '0, lamp;
    logic [63:0] trig;
    logic flag, ev, rd_e;
    logic [31:0] rd_v;
    lmp_pkg::lmp_apb_req_t req = '0;
    lmp_pkg::lmp_apb_rsp_t rsp;
    int err_count = 0, compares = 0, n;
    always #2 clk = ~clk;
    lmp_trig_model u_trig (.clk(clk), .press(press), .glitch(glitch),
        .sel(6'h05), .trig_src(trig));
    lmp_sequencer #(.STEP_CYC(8), .HOLD_LIMIT_CYC(200), .PULSE_MIN_CYC(3))
    dut (.CLK(clk), .RESET(rst), .APB_REQ(req), .APB_RSP(rsp),
        .TRIG_SRC(trig), .USER_OPERAND(tv[49:2]), .TRIP_OPERAND(tv[0]),
        .ALARM_OPERAND(tv[1]), .PB_LAMP_STATE(tv[61:50]),
        .RESET_OPERAND(ro), .FACEPLATE_RESET_PIN(fp), .LAMP(lamp),
        .LAMP_CHECK_ACTIVE_FLAG(flag), .LAMP_CHECK_STARTED_EVENT(ev));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] s, x);
        compares++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        if (k == 50) err_count++;
        rd_v = rsp.prdata;
        rd_e = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wait_on(input logic v);
        n = 0;
        while (flag !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic wait_dark();
        n = 0;
        while (lamp !== 62'h0 && n < 50) begin
            @(posedge clk);
            n++;
        end
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(5000);
        err_count++;
        finish_test();
    end
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(8);
        rst <= 1'b0;
        cyc(2);
        chk("reset out", {flag, ev, lamp}, 0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset reg", rd_v, (i == 4) ? 32'h10 : 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd_e, 1);
        foreach (rows[i]) begin
            tv <= rows[i].in;
            cyc(4);
            chk("row lamp", lamp, rows[i].out);
        end
        $display("test rows done");
        apb(1'b1, lmp_pkg::ADDR_TYPE_LO, 32'h1);
        tv[2] <= 1'b1;
        cyc(3);
        tv[2] <= 1'b0;
        cyc(4);
        chk("latched", lamp[2], 1);
        ro <= 1'b1;
        cyc(1);
        ro <= 1'b0;
        cyc(2);
        chk("operand clear", lamp[2], 0);
        tv[2] <= 1'b1;
        cyc(4);
        tv[2] <= 1'b0;
        fp <= 1'b1;
        cyc(3);
        fp <= 1'b0;
        cyc(5);
        chk("faceplate clear", lamp[2], 0);
        // Right source selected but test disabled: only the enable gates
        apb(1'b1, lmp_pkg::ADDR_CTRL, 32'h0500);
        press <= 1'b1;
        cyc(10);
        chk("disabled", flag, 0);
        press <= 1'b0;
        apb(1'b1, lmp_pkg::ADDR_CTRL, 32'h0501);
        // Let the released press be accepted low before the glitch
        cyc(4);
        glitch <= 1'b1;
        cyc(2);
        glitch <= 1'b0;
        cyc(8);
        chk("short pulse", flag, 0);
        $display("test latch and start gate done");
        press <= 1'b1;
        wait_on(1'b1);
        chk("event", ev, 1);
        chk("all on", lamp, {62{1'b1}});
        tv[2] <= 1'b1;
        cyc(2);
        tv[2] <= 1'b0;
        tv[7] <= 1'b1;
        fp <= 1'b1;
        cyc(4);
        fp <= 1'b0;
        press <= 1'b0;
        wait_dark();
        chk("stage two blank", lamp, 0);
        n = 0;
        while (flag === 1'b1 && n < 1100) begin
            @(posedge clk);
            n++;
            if (n == 8) chk("first lamp", lamp, 62'h1);
            if (n == 496) chk("last lamp", lamp, 62'h1 << 61);
            if (n == 504) chk("stage three", lamp, {62{1'b1}});
            if (n == 512) chk("first dark", lamp,
                62'h3fff_ffff_ffff_fffe);
        end
        chk("test length", n >= 1008 && n <= 1010, 1);
        cyc(2);
        chk("true states", lamp, 62'h84);
        $display("test full sequence done");
        tv <= '0;
        apb(1'b1, lmp_pkg::ADDR_CMD, 32'h1);
        press <= 1'b1;
        wait_on(1'b1);
        press <= 1'b0;
        wait_dark();
        cyc(20);
        press <= 1'b1;
        cyc(8);
        chk("abort", flag, 0);
        press <= 1'b0;
        cyc(10);
        chk("abort stays", lamp, 0);
        press <= 1'b1;
        wait_on(1'b1);
        cyc(210);
        chk("hold limit", flag, 0);
        press <= 1'b0;
        cyc(10);
        chk("no restart", flag, 0);
        apb(1'b0, lmp_pkg::ADDR_EVCNT, 32'h0);
        chk("start count", rd_v, 3);
        // Reset in the middle of a running test
        press <= 1'b1;
        wait_on(1'b1);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        press <= 1'b0;
        cyc(2);
        chk("mid reset", {flag, ev, lamp}, 0);
        $display("test abort and limit done");
        finish_test();
    end
endmodule
